/* File: pkg/pci_target_addon_bridge_map.vh */
// Register offsets, field positions and reset values of the target bridge.
// Included by the bridge core; holds definitions only.
`ifndef PCI_TARGET_ADDON_BRIDGE_MAP_VH
`define PCI_TARGET_ADDON_BRIDGE_MAP_VH

// Host-side byte offsets, below the bridged window (address bit 31 low).
`define OFF_MB_OUT 8'h00
`define OFF_MB_IN 8'h04
`define OFF_MB_STAT 8'h08
`define OFF_INT_CFG 8'h0C
`define OFF_BR_CTRL 8'h10
`define OFF_CFG_ID 8'h14
`define OFF_REGION0 8'h20
`define OFF_REGION1 8'h24
`define OFF_REGION2 8'h28
`define OFF_REGION3 8'h2C

// Add-on register port indices.
`define AO_MB_OUT 3'h0
`define AO_MB_IN 3'h1
`define AO_MB_STAT 3'h2
`define AO_INT_CFG 3'h3
`define AO_BR_CTRL 3'h4

// Interrupt configuration fields.
`define INT_PCI_SEL 0
`define INT_PCI_EN 2
`define INT_AO_SEL 3
`define INT_AO_EN 5
`define INT_DIRECT_EN 6
`define INT_PCI_FLAG 8
`define INT_AO_FLAG 9

// Bridge control fields.
`define CTRL_WFIFO_EN 0
`define CTRL_RFIFO_EN 1
`define CTRL_ACTIVE 2
`define CTRL_WAIT 3
`define CTRL_BUSY 8

// Region configuration fields; width code 0 = 8, 1 = 16, 2 = 32 bits.
`define REG_WIDTH 0
`define REG_IO 2
`define REG_EN 3
`define REG_SIZE 4

// Reset values.
`define INT_CFG_RST 7'h00
`define CTRL_RST 6'h00
`define REGION_RST 32'h00000000

// Configuration loader indices.
`define NV_ID_IDX 3'h0

`endif

/* File: core/pci_target_addon_bridge.v */
// Target-only bridge: host registers on a classic Wishbone slave, add-on
// registers, mailboxes and four bridged regions toward add-on user logic.
// Assumes add-on pins are asynchronous to clk_i and the loader port is not.
`timescale 1ns/1ns
`include "pci_target_addon_bridge_map.vh"
module pci_target_addon_bridge #(
	parameter AW = 3,
	parameter [31:0] CFG_ID_DEFAULT = 32'h00A5005A // Arbitrary value.
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	output wire wb_rty_o,
	input wire nv_valid_i,
	input wire [2:0] nv_index_i,
	input wire [31:0] nv_data_i,
	input wire addon_sel_n_i,
	input wire addon_rd_n_i,
	input wire addon_wr_n_i,
	input wire [2:0] addon_adr_i,
	input wire [3:0] addon_be_n_i,
	input wire [31:0] addon_wdata_i,
	output wire [31:0] addon_rdata_o,
	input wire [7:0] mailbox_direct_data_i,
	input wire mailbox_load_n_i,
	output wire pci_irq_o,
	output wire addon_irq_o,
	output wire bridge_request_flag_n_o,
	output wire bridge_burst_flag_n_o,
	output wire bridge_write_dir_o,
	output wire [3:0] bridge_lane_enable_n_o,
	output wire [1:0] bridge_region_index_o,
	output wire [1:0] bridge_width_o,
	output wire bridge_io_space_o,
	output wire [28:0] bridge_addr_o,
	output wire [31:0] bridge_wdata_o,
	input wire [31:0] bridge_rdata_i,
	input wire bridge_ready_or_hold_n_i,
	output wire addon_strobe_n_o,
	output wire addon_strobe_oe_o
);
	localparam DEPTH = 1 << AW;
	localparam [AW:0] FULL_CNT = {1'b1, {AW{1'b0}}};
	localparam SW = 84;
	localparam [1:0] ENG_IDLE = 2'h0;
	localparam [1:0] ENG_REQ = 2'h1;
	localparam [1:0] ENG_PARK = 2'h2;
	localparam [1:0] ENG_GAP = 2'h3;

	// Add-on pins pass two flip-flops; only sync2_r and later are read.
	reg [SW-1:0] sync1_r;
	reg [SW-1:0] sync2_r;
	reg [4:0] prev_r;
	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= {SW{1'b1}};
			sync2_r <= {SW{1'b1}};
			prev_r <= 5'h1F;
		end else begin
			sync1_r <= {mailbox_load_n_i, bridge_ready_or_hold_n_i,
				addon_sel_n_i, addon_rd_n_i, addon_wr_n_i, addon_adr_i,
				addon_be_n_i, addon_wdata_i, bridge_rdata_i,
				mailbox_direct_data_i};
			sync2_r <= sync1_r;
			prev_r <= sync2_r[83:79];
		end
	end
	wire s_load_n = sync2_r[83];
	wire s_ready_n = sync2_r[82];
	wire s_sel_n = sync2_r[81];
	wire [2:0] s_adr = sync2_r[78:76];
	wire [3:0] s_be = ~sync2_r[75:72];
	wire [31:0] s_wdata = sync2_r[71:40];
	wire [31:0] s_rdata = sync2_r[39:8];
	wire [7:0] s_direct = sync2_r[7:0];
	wire load_fall = prev_r[4] & ~s_load_n;
	wire ao_rd = prev_r[1] & ~sync2_r[80] & ~s_sel_n;
	wire ao_wr = prev_r[0] & ~sync2_r[79] & ~s_sel_n;

	// Host request decode; effects happen once, in the cycle before ack or retry.
	reg ack_r;
	reg rty_r;
	reg [31:0] wb_dat_r;
	wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r & ~rty_r;
	wire br_sel = wb_adr_i[31];
	wire [7:0] off = wb_adr_i[7:0];
	wire reg_wr = wb_req & wb_we_i & ~br_sel;
	wire reg_rd = wb_req & ~wb_we_i & ~br_sel;
	wire [1:0] br_reg = wb_adr_i[30:29];
	wire [28:0] br_off = {wb_adr_i[28:2], 2'b00};

	// Region configuration, one entry per region.
	wire [31:0] region_w [0:3];
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : rgn
			localparam integer GI = g;
			localparam [7:0] MY_OFF = `OFF_REGION0 + {GI[5:0], 2'b00};
			localparam [2:0] NV_IDX = 3'h4 + GI[2:0];
			reg [31:0] cfg_r;
			always @(posedge clk_i) begin
				if (rst_i) begin
					cfg_r <= `REGION_RST;
				end else if (nv_valid_i && nv_index_i == NV_IDX) begin
					cfg_r <= nv_data_i;
				end else if (reg_wr && off == MY_OFF) begin
					cfg_r <= wb_dat_i;
				end
			end
			assign region_w[g] = cfg_r;
		end
	endgenerate
	wire [31:0] rcfg = region_w[br_reg];
	wire br_hit = rcfg[`REG_EN] &
		((br_off >> rcfg[`REG_SIZE +: 5]) == 29'h0);

	reg [31:0] cfg_id_r;
	reg [6:0] int_cfg_r;
	reg pci_flag_r;
	reg ao_flag_r;
	reg [5:0] ctrl_r;
	wire wf_en = ctrl_r[`CTRL_WFIFO_EN];
	wire rf_en = ctrl_r[`CTRL_RFIFO_EN];
	wire active = ctrl_r[`CTRL_ACTIVE];
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_id_r <= CFG_ID_DEFAULT;
			ctrl_r <= `CTRL_RST;
		end else begin
			if (nv_valid_i && nv_index_i == `NV_ID_IDX) begin
				cfg_id_r <= nv_data_i;
			end
			if (reg_wr && off == `OFF_BR_CTRL && wb_sel_i[0]) begin
				ctrl_r <= wb_dat_i[5:0];
			end
		end
	end

	// Mailbox bytes: inbound written by host, outbound by add-on or pins.
	wire [31:0] mb_in_w;
	wire [31:0] mb_out_w;
	wire [3:0] in_full_w;
	wire [3:0] out_full_w;
	wire wr_in = reg_wr & (off == `OFF_MB_IN);
	wire rd_out = reg_rd & (off == `OFF_MB_OUT);
	wire ao_wr_out = ao_wr & (s_adr == `AO_MB_OUT);
	wire ao_rd_in = ao_rd & (s_adr == `AO_MB_IN);
	generate
		for (g = 0; g < 4; g = g + 1) begin : mbx
			reg [7:0] in_r;
			reg [7:0] out_r;
			reg in_full_r;
			reg out_full_r;
			wire load_here = load_fall & (g == 0);
			always @(posedge clk_i) begin
				if (rst_i) begin
					in_r <= 8'h00;
					out_r <= 8'h00;
					in_full_r <= 1'b0;
					out_full_r <= 1'b0;
				end else begin
					if (wr_in && wb_sel_i[g]) begin
						in_r <= wb_dat_i[8*g +: 8];
						in_full_r <= 1'b1;
					end else if (ao_rd_in && s_be[g]) begin
						in_full_r <= 1'b0;
					end
					if (load_here) begin
						out_r <= s_direct;
						out_full_r <= 1'b1;
					end else if (ao_wr_out && s_be[g]) begin
						out_r <= s_wdata[8*g +: 8];
						out_full_r <= 1'b1;
					end else if (rd_out && wb_sel_i[g]) begin
						out_full_r <= 1'b0;
					end
				end
			end
			assign mb_in_w[8*g +: 8] = in_r;
			assign mb_out_w[8*g +: 8] = out_r;
			assign in_full_w[g] = in_full_r;
			assign out_full_w[g] = out_full_r;
		end
	endgenerate
	wire [31:0] stat_w = {24'h000000, out_full_w, in_full_w};

	// Mailbox interrupts; a new event wins over a clear in the same cycle.
	wire pci_ev = (ao_wr_out & s_be[int_cfg_r[`INT_PCI_SEL +: 2]] &
		int_cfg_r[`INT_PCI_EN]) | (load_fall & int_cfg_r[`INT_DIRECT_EN]);
	wire ao_ev = wr_in & wb_sel_i[int_cfg_r[`INT_AO_SEL +: 2]] &
		int_cfg_r[`INT_AO_EN];
	wire int_wr = reg_wr & (off == `OFF_INT_CFG);
	wire ao_int_wr = ao_wr & (s_adr == `AO_INT_CFG) & s_be[1];
	always @(posedge clk_i) begin
		if (rst_i) begin
			int_cfg_r <= `INT_CFG_RST;
			pci_flag_r <= 1'b0;
			ao_flag_r <= 1'b0;
		end else begin
			if (int_wr && wb_sel_i[0]) begin
				int_cfg_r <= wb_dat_i[6:0];
			end
			if (pci_ev) begin
				pci_flag_r <= 1'b1;
			end else if ((int_wr && wb_sel_i[1] && wb_dat_i[8]) ||
				(ao_int_wr && s_wdata[8])) begin
				pci_flag_r <= 1'b0;
			end
			if (ao_ev) begin
				ao_flag_r <= 1'b1;
			end else if ((int_wr && wb_sel_i[1] && wb_dat_i[9]) ||
				(ao_int_wr && s_wdata[9])) begin
				ao_flag_r <= 1'b0;
			end
		end
	end
	assign pci_irq_o = pci_flag_r;
	assign addon_irq_o = ao_flag_r;

	// Write FIFO entry: region, lanes, offset, data; read FIFO holds data.
	reg [66:0] wf_mem [0:DEPTH-1];
	reg [AW:0] wf_wp_r;
	reg [AW:0] wf_rp_r;
	reg [31:0] rf_mem [0:DEPTH-1];
	reg [AW:0] rf_wp_r;
	reg [AW:0] rf_rp_r;
	wire [AW:0] wf_cnt = wf_wp_r - wf_rp_r;
	wire [AW:0] rf_cnt = rf_wp_r - rf_rp_r;
	reg [1:0] eng_r;
	reg [31:0] rt_data_r;
	reg rt_taken_r;
	reg rt_done_tgl_r;

	// Host-side bridge state: pending real-time access and prefetch window.
	reg rt_pend_r;
	reg rt_req_tgl_r;
	reg rt_we_r;
	reg [1:0] rt_reg_r;
	reg [28:0] rt_off_r;
	reg [3:0] rt_sel_r;
	reg [31:0] rt_wd_r;
	reg pf_on_r;
	reg pf_gen_r;
	reg [1:0] pf_reg_r;
	reg [28:0] pf_head_r;
	wire rt_done = rt_pend_r & (rt_done_tgl_r == rt_req_tgl_r);
	wire rt_match = rt_we_r == wb_we_i && rt_reg_r == br_reg &&
		rt_off_r == br_off;
	wire pf_match = pf_on_r && pf_reg_r == br_reg && pf_head_r == br_off;
	// A restart in the same cycle as a prefetch store must drop that word.
	wire rf_flush = wb_req & ~wb_we_i & rf_en & br_sel & br_hit & ~pf_match;
	reg [31:0] rd_mux;
	always @* begin
		case (off)
		`OFF_MB_OUT: rd_mux = mb_out_w;
		`OFF_MB_IN: rd_mux = mb_in_w;
		`OFF_MB_STAT: rd_mux = stat_w;
		`OFF_INT_CFG: rd_mux = {22'h000000, ao_flag_r, pci_flag_r,
			1'b0, int_cfg_r};
		`OFF_BR_CTRL: rd_mux = {23'h000000, eng_r != ENG_IDLE, 2'h0,
			ctrl_r};
		`OFF_CFG_ID: rd_mux = cfg_id_r;
		`OFF_REGION0: rd_mux = region_w[0];
		`OFF_REGION1: rd_mux = region_w[1];
		`OFF_REGION2: rd_mux = region_w[2];
		`OFF_REGION3: rd_mux = region_w[3];
		default: rd_mux = 32'h00000000;
		endcase
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rty_r <= 1'b0;
			wb_dat_r <= 32'h00000000;
			wf_wp_r <= {(AW+1){1'b0}};
			rf_rp_r <= {(AW+1){1'b0}};
			rt_pend_r <= 1'b0;
			rt_req_tgl_r <= 1'b0;
			rt_we_r <= 1'b0;
			rt_reg_r <= 2'h0;
			rt_off_r <= 29'h0;
			rt_sel_r <= 4'h0;
			rt_wd_r <= 32'h00000000;
			pf_on_r <= 1'b0;
			pf_gen_r <= 1'b0;
			pf_reg_r <= 2'h0;
			pf_head_r <= 29'h0;
		end else begin
			ack_r <= 1'b0;
			rty_r <= 1'b0;
			if (wb_req && (!br_sel || !br_hit)) begin
				ack_r <= 1'b1;
				wb_dat_r <= br_sel ? 32'h00000000 : rd_mux;
			end else if (wb_req && wb_we_i && wf_en) begin
				// Any write invalidates prefetched data to keep reads fresh.
				pf_on_r <= 1'b0;
				if (wf_cnt != FULL_CNT) begin
					wf_mem[wf_wp_r[AW-1:0]] <= {br_reg, wb_sel_i, br_off,
						wb_dat_i};
					wf_wp_r <= wf_wp_r + 1'b1;
					ack_r <= 1'b1;
				end else begin
					rty_r <= 1'b1;
				end
			end else if (wb_req && !wb_we_i && rf_en) begin
				if (pf_match && rf_cnt != 0) begin
					ack_r <= 1'b1;
					wb_dat_r <= rf_mem[rf_rp_r[AW-1:0]];
					rf_rp_r <= rf_rp_r + 1'b1;
					pf_head_r <= pf_head_r + 29'h4;
				end else begin
					rty_r <= 1'b1;
					if (!pf_match) begin
						rf_rp_r <= rf_wp_r;
						pf_gen_r <= ~pf_gen_r;
						pf_on_r <= 1'b1;
						pf_reg_r <= br_reg;
						pf_head_r <= br_off;
					end
				end
			end else if (wb_req) begin
				if (rt_pend_r && rt_match && rt_done) begin
					ack_r <= 1'b1;
					wb_dat_r <= rt_data_r;
					rt_pend_r <= 1'b0;
				end else begin
					rty_r <= 1'b1;
					if (!rt_pend_r) begin
						rt_pend_r <= 1'b1;
						rt_req_tgl_r <= ~rt_req_tgl_r;
						rt_we_r <= wb_we_i;
						rt_reg_r <= br_reg;
						rt_off_r <= br_off;
						rt_sel_r <= wb_sel_i;
						rt_wd_r <= wb_dat_i;
						pf_on_r <= pf_on_r & ~wb_we_i;
					end
				end
			end
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_rty_o = rty_r;
	assign wb_dat_o = wb_dat_r;

	// Add-on engine: one word per job, write FIFO first, then real time,
	// then prefetch. PARK then GAP keep the shared strobe safe to hand over.
	reg [2:0] wait_r;
	reg job_we_r;
	reg job_rt_r;
	reg job_gen_r;
	reg job_burst_r;
	reg [1:0] job_reg_r;
	reg [3:0] job_sel_r;
	reg [28:0] job_off_r;
	reg [31:0] job_wd_r;
	reg [28:0] fill_r;
	reg seen_gen_r;
	reg strobe_n_r;
	reg strobe_oe_r;
	wire [66:0] wf_head = wf_mem[wf_rp_r[AW-1:0]];
	wire job_done = active ? (wait_r == ctrl_r[`CTRL_WAIT +: 3]) :
		~s_ready_n;
	wire [31:0] jcfg = region_w[job_reg_r];
	wire eng_pick = seen_gen_r == pf_gen_r && (wf_cnt != 0 ||
		rt_taken_r != rt_req_tgl_r || (pf_on_r && rf_cnt != FULL_CNT));
	always @(posedge clk_i) begin
		if (rst_i) begin
			eng_r <= ENG_IDLE;
			wf_rp_r <= {(AW+1){1'b0}};
			rf_wp_r <= {(AW+1){1'b0}};
			rt_taken_r <= 1'b0;
			rt_done_tgl_r <= 1'b0;
			rt_data_r <= 32'h00000000;
			wait_r <= 3'h0;
			job_we_r <= 1'b0;
			job_rt_r <= 1'b0;
			job_gen_r <= 1'b0;
			job_burst_r <= 1'b0;
			job_reg_r <= 2'h0;
			job_sel_r <= 4'h0;
			job_off_r <= 29'h0;
			job_wd_r <= 32'h00000000;
			fill_r <= 29'h0;
			seen_gen_r <= 1'b0;
			strobe_n_r <= 1'b1;
			strobe_oe_r <= 1'b0;
		end else begin
			case (eng_r)
			ENG_IDLE: begin
				wait_r <= 3'h0;
				if (seen_gen_r != pf_gen_r) begin
					seen_gen_r <= pf_gen_r;
					fill_r <= pf_head_r;
				end else if (wf_cnt != 0) begin
					{job_reg_r, job_sel_r, job_off_r, job_wd_r} <= wf_head;
					wf_rp_r <= wf_rp_r + 1'b1;
					job_we_r <= 1'b1;
					job_rt_r <= 1'b0;
					job_burst_r <= wf_cnt > 1;
					eng_r <= ENG_REQ;
				end else if (rt_taken_r != rt_req_tgl_r) begin
					rt_taken_r <= rt_req_tgl_r;
					{job_reg_r, job_sel_r, job_off_r} <=
						{rt_reg_r, rt_sel_r, rt_off_r};
					job_wd_r <= rt_wd_r;
					job_we_r <= rt_we_r;
					job_rt_r <= 1'b1;
					job_burst_r <= 1'b0;
					eng_r <= ENG_REQ;
				end else if (pf_on_r && rf_cnt != FULL_CNT) begin
					job_reg_r <= pf_reg_r;
					job_sel_r <= 4'hF;
					job_off_r <= fill_r;
					job_gen_r <= pf_gen_r;
					job_we_r <= 1'b0;
					job_rt_r <= 1'b0;
					job_burst_r <= 1'b1;
					fill_r <= fill_r + 29'h4;
					eng_r <= ENG_REQ;
				end
				// In active mode the strobe is low for the whole job and is driven again
				// only after GAP and IDLE have left it undriven.
				strobe_n_r <= ~(active & eng_pick);
				strobe_oe_r <= active & eng_pick;
			end
			ENG_REQ: begin
				// Completion returns the strobe high for one parked clock.
				strobe_n_r <= ~active | job_done;
				strobe_oe_r <= active;
				if (active) begin
					wait_r <= wait_r + 3'h1;
				end
				if (job_done) begin
					eng_r <= ENG_PARK;
					if (job_rt_r) begin
						if (!job_we_r) begin
							rt_data_r <= s_rdata;
						end
						rt_done_tgl_r <= rt_taken_r;
					end else if (!job_we_r && job_gen_r == pf_gen_r &&
						!rf_flush) begin
						rf_mem[rf_wp_r[AW-1:0]] <= s_rdata;
						rf_wp_r <= rf_wp_r + 1'b1;
					end
				end
			end
			ENG_PARK: begin
				strobe_n_r <= 1'b1;
				strobe_oe_r <= 1'b0;
				eng_r <= ENG_GAP;
			end
			ENG_GAP: begin
				strobe_oe_r <= 1'b0;
				eng_r <= ENG_IDLE;
			end
			default: eng_r <= ENG_IDLE;
			endcase
		end
	end
	assign bridge_request_flag_n_o = ~(eng_r == ENG_REQ);
	assign bridge_burst_flag_n_o = ~job_burst_r;
	assign bridge_write_dir_o = job_we_r;
	assign bridge_lane_enable_n_o = ~job_sel_r;
	assign bridge_region_index_o = job_reg_r;
	assign bridge_width_o = jcfg[`REG_WIDTH +: 2];
	assign bridge_io_space_o = jcfg[`REG_IO];
	assign bridge_addr_o = job_off_r;
	assign bridge_wdata_o = job_wd_r;
	assign addon_strobe_n_o = strobe_n_r;
	assign addon_strobe_oe_o = strobe_oe_r;

	// Add-on register reads return one cycle after the strobe edge is seen.
	reg [31:0] ao_rdata_r;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ao_rdata_r <= 32'h00000000;
		end else if (ao_rd) begin
			case (s_adr)
			`AO_MB_IN: ao_rdata_r <= mb_in_w;
			`AO_MB_OUT: ao_rdata_r <= mb_out_w;
			`AO_MB_STAT: ao_rdata_r <= stat_w;
			`AO_INT_CFG: ao_rdata_r <= {22'h000000, ao_flag_r,
				pci_flag_r, 1'b0, int_cfg_r};
			`AO_BR_CTRL: ao_rdata_r <= {26'h0000000, ctrl_r};
			default: ao_rdata_r <= 32'h00000000;
			endcase
		end
	end
	assign addon_rdata_o = ao_rdata_r;
endmodule

/* File: dv/pci_target_addon_bridge_props.sv */
// Concurrent checks on the host bus, bridge job pins and engine strobe.
// Assumes the top module's ports and the hand-over timing of the bridge.
`timescale 1ns/1ns
module pci_target_addon_bridge_props (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire wb_rty_o,
	input wire pci_irq_o,
	input wire addon_irq_o,
	input wire bridge_request_flag_n_o,
	input wire [1:0] bridge_region_index_o,
	input wire [28:0] bridge_addr_o,
	input wire [31:0] bridge_wdata_o,
	input wire addon_strobe_n_o,
	input wire addon_strobe_oe_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_rty_o;
	endsequence
	sequence s_answer;
		wb_ack_o || wb_rty_o;
	endsequence
	sequence s_park;
		addon_strobe_n_o && addon_strobe_oe_o;
	endsequence
	AST_ANSWER_NEXT: assert property (s_taken |=> s_answer)
		else $error("request not answered in the next cycle");
	AST_ACK_RTY_EXCL: assert property (!(wb_ack_o && wb_rty_o))
		else $error("ack and retry together");
	AST_ANSWER_PULSE: assert property (s_answer |=> !wb_ack_o && !wb_rty_o)
		else $error("answer longer than one cycle");
	AST_NO_STRAY: assert property (s_answer |-> $past(wb_cyc_i && wb_stb_i))
		else $error("answer without a request");
	AST_JOB_STABLE: assert property (!bridge_request_flag_n_o &&
		$past(!bridge_request_flag_n_o) |-> $stable(bridge_addr_o) &&
		$stable(bridge_wdata_o) && $stable(bridge_region_index_o))
		else $error("job fields moved during a job");
	AST_JOB_GAP: assert property ($rose(bridge_request_flag_n_o) |=>
		bridge_request_flag_n_o [*2])
		else $error("jobs closer than allowed");
	AST_RELEASE_HIGH: assert property ($fell(addon_strobe_oe_o) |->
		addon_strobe_n_o && $past(addon_strobe_n_o))
		else $error("strobe released without a high cycle");
	AST_REDRIVE_GAP: assert property (s_park ##1 !addon_strobe_oe_o |=>
		!addon_strobe_oe_o)
		else $error("strobe driven again too soon");
	AST_STROBE_IN_JOB: assert property (!addon_strobe_n_o |->
		!bridge_request_flag_n_o && addon_strobe_oe_o)
		else $error("strobe outside a driven job");
	AST_RESET_IDLE: assert property (disable iff (1'b0)
		rst_i |=> !wb_ack_o && !wb_rty_o && bridge_request_flag_n_o &&
		!addon_strobe_oe_o && !pci_irq_o && !addon_irq_o)
		else $error("outputs not idle after reset");
endmodule
bind pci_target_addon_bridge pci_target_addon_bridge_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_rty_o(wb_rty_o),
	.pci_irq_o(pci_irq_o), .addon_irq_o(addon_irq_o),
	.bridge_request_flag_n_o(bridge_request_flag_n_o),
	.bridge_region_index_o(bridge_region_index_o),
	.bridge_addr_o(bridge_addr_o), .bridge_wdata_o(bridge_wdata_o),
	.addon_strobe_n_o(addon_strobe_n_o),
	.addon_strobe_oe_o(addon_strobe_oe_o));

/* File: dv/addon_user_model.sv */
// Add-on user logic that serves bridge jobs in passive mode.
// Assumes job fields are launched from clk_i and held through the job.
`timescale 1ns/1ns
module addon_user_model (
	input wire clk_i,
	input wire req_n_i,
	input wire [28:0] addr_i,
	input wire [31:0] wdata_i,
	input wire [7:0] dly_i,
	output reg ready_n_o,
	output reg [31:0] rdata_o,
	output reg [31:0] last_wdata_o,
	output reg [7:0] n_jobs_o
);
	reg [7:0] cnt_r;
	initial begin
		ready_n_o = 1'b1;
		rdata_o = 32'h0;
		last_wdata_o = 32'h0;
		n_jobs_o = 8'h0;
		cnt_r = 8'h0;
	end
	always @(posedge clk_i) begin
		if (!req_n_i) begin
			rdata_o <= 32'hC0DE0000 ^ {3'h0, addr_i};
			cnt_r <= cnt_r + 8'h1;
			if (cnt_r == dly_i) begin
				ready_n_o <= 1'b0;
				last_wdata_o <= wdata_i;
				n_jobs_o <= n_jobs_o + 8'h1;
			end
		end else begin
			// Released data is inverted so stale values never look valid.
			rdata_o <= ~(32'hC0DE0000 ^ {3'h0, addr_i});
			cnt_r <= 8'h0;
			ready_n_o <= 1'b1;
		end
	end
endmodule

/* File: dv/test_pci_target_addon_bridge.sv */
// Self-checking bench: host bus tasks, add-on strobes and a user model.
// Assumes the hand-over timing of the bridge and a 10 MHz clock.
`timescale 1ns/1ns
module test_pci_target_addon_bridge;
	localparam [31:0] ID = 32'h00C33C00; // Arbitrary identity value.
	localparam [31:0] ALL = 32'hFFFFFFFF;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg cyc = 1'b0;
	reg we = 1'b0;
	reg [31:0] adr = 32'h0;
	reg [3:0] sel = 4'h0;
	reg [31:0] wdat = 32'h0;
	reg nv_v = 1'b0;
	reg [31:0] nv_d = 32'h0;
	reg [2:0] nv_i = 3'h0;
	reg ao_sel_n = 1'b1;
	reg ao_rd_n = 1'b1;
	reg ao_wr_n = 1'b1;
	reg [2:0] ao_adr = 3'h0;
	reg [3:0] ao_be_n = 4'hF;
	reg [31:0] ao_wd = 32'h0;
	reg [7:0] md = 8'h0;
	reg md_ld_n = 1'b1;
	reg [7:0] dly = 8'h3;
	reg [10:0] jf = 11'h0;
	reg [31:0] d, a, exp_q[$], msk_q[$];
	reg got;
	integer n_errors = 0, check_count = 0, tries, rl, i, r, w;
	wire [31:0] rdat, ao_rd, bwd, brd, p_lwd;
	wire ack, rty, pirq, airq, req_n, burst_n, wdir, io, rdy_n, stb_n, oe;
	wire [3:0] lanes_n;
	wire [1:0] ridx, width;
	wire [28:0] baddr;
	wire [7:0] p_jobs;
	pci_target_addon_bridge #(.AW(3), .CFG_ID_DEFAULT(ID))
		u_pci_target_addon_bridge (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_rty_o(rty),
		.nv_valid_i(nv_v), .nv_index_i(nv_i), .nv_data_i(nv_d),
		.addon_sel_n_i(ao_sel_n), .addon_rd_n_i(ao_rd_n),
		.addon_wr_n_i(ao_wr_n), .addon_adr_i(ao_adr),
		.addon_be_n_i(ao_be_n), .addon_wdata_i(ao_wd),
		.addon_rdata_o(ao_rd), .mailbox_direct_data_i(md),
		.mailbox_load_n_i(md_ld_n), .pci_irq_o(pirq), .addon_irq_o(airq),
		.bridge_request_flag_n_o(req_n), .bridge_burst_flag_n_o(burst_n),
		.bridge_write_dir_o(wdir), .bridge_lane_enable_n_o(lanes_n),
		.bridge_region_index_o(ridx), .bridge_width_o(width),
		.bridge_io_space_o(io), .bridge_addr_o(baddr),
		.bridge_wdata_o(bwd), .bridge_rdata_i(brd),
		.bridge_ready_or_hold_n_i(rdy_n), .addon_strobe_n_o(stb_n),
		.addon_strobe_oe_o(oe));
	addon_user_model u_addon_user_model (
		.clk_i(clk_i), .req_n_i(req_n), .addr_i(baddr), .wdata_i(bwd),
		.dly_i(dly), .ready_n_o(rdy_n), .rdata_o(brd),
		.last_wdata_o(p_lwd), .n_jobs_o(p_jobs));
	always #50 clk_i = ~clk_i;
	task check(input [31:0] seen, input [31:0] want);
		begin
			check_count = check_count + 1;
			if (seen !== want) begin
				n_errors = n_errors + 1;
				$display("unexpected at %0t: %h vs %h", $time, seen, want);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", check_count, n_errors);
			if (n_errors == 0 && check_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// Retried requests repeat the same address and direction.
	task wb(input w_i, input [31:0] a_i, input [31:0] d_i,
		input [3:0] s_i, input [31:0] m_i);
		begin
			tries = 0;
			got = 1'b0;
			if (!w_i) begin
				exp_q.push_back(d_i);
				msk_q.push_back(m_i);
			end
			while (!got) begin
				cyc <= 1'b1;
				we <= w_i;
				adr <= a_i;
				wdat <= d_i;
				sel <= s_i;
				@(posedge clk_i);
				while (!(ack || rty))
					@(posedge clk_i);
				cyc <= 1'b0;
				got = ack;
				tries = tries + (rty ? 1 : 0);
				@(posedge clk_i);
			end
		end
	endtask
	task ao(input w_i, input [2:0] i_i, input [3:0] b_i, input [31:0] d_i);
		begin
			ao_sel_n <= 1'b0;
			ao_adr <= i_i;
			ao_be_n <= b_i;
			ao_wd <= d_i;
			repeat (3) @(posedge clk_i);
			ao_wr_n <= !w_i;
			ao_rd_n <= w_i;
			repeat (6) @(posedge clk_i);
			ao_wr_n <= 1'b1;
			ao_rd_n <= 1'b1;
			repeat (4) @(posedge clk_i);
			ao_sel_n <= 1'b1;
			@(posedge clk_i);
		end
	endtask
	always @(posedge clk_i) begin
		if (ack && cyc && !we) begin
			check(rdat & msk_q[0], exp_q[0] & msk_q[0]);
			exp_q.pop_front();
			msk_q.pop_front();
		end
		if (!req_n) begin
			jf <= {wdir, burst_n, lanes_n, ridx, width, io};
			rl <= rl + 1;
		end
	end
	initial begin
		#(30000 * 100);
		n_errors = n_errors + 1;
		report_and_stop;
	end
	initial begin
		d = $urandom(91);
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 12; i = i + 1)
			if (i != 1)
				wb(0, i * 4, (i == 5) ? ID : 32'h0, 4'hF, ALL);
		nv_v <= 1'b1;
		nv_d <= d;
		@(posedge clk_i);
		nv_v <= 1'b0;
		@(posedge clk_i);
		wb(0, 32'h14, d, 4'hF, ALL);
		nv_i <= 3'h6;
		nv_v <= 1'b1;
		nv_d <= ~d;
		@(posedge clk_i);
		nv_v <= 1'b0;
		@(posedge clk_i);
		wb(0, 32'h28, ~d, 4'hF, ALL);
		d = $urandom;
		wb(1, 32'h04, d, 4'hF, 0);
		wb(0, 32'h08, 32'h0F, 4'hF, 32'hFF);
		ao(0, 3'h2, 4'h0, 0);
		check(ao_rd & 32'hFF, 32'h0F);
		ao(0, 3'h1, 4'h0, 0);
		check(ao_rd, d);
		wb(0, 32'h08, 0, 4'hF, 32'hFF);
		ao(1, 3'h0, 4'h0, ~d);
		wb(1, 32'h00, d, 4'hF, 0);
		wb(0, 32'h08, 32'hF0, 4'hF, 32'hFF);
		wb(0, 32'h00, ~d, 4'hF, ALL);
		wb(0, 32'h08, 0, 4'hF, 32'hFF);
		wb(1, 32'h0C, 32'h2E, 4'hF, 0);
		ao(1, 3'h0, 4'hB, d);
		check(pirq, 1);
		wb(1, 32'h0C, 32'h100, 4'h2, 0);
		check(pirq, 0);
		wb(1, 32'h04, d, 4'h2, 0);
		check(airq, 1);
		ao(1, 3'h3, 4'hD, 32'h200);
		check(airq, 0);
		wb(1, 32'h0C, 32'h44, 4'h1, 0);
		md <= d[15:8];
		@(posedge clk_i);
		md_ld_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		md_ld_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		check(pirq, 1);
		wb(0, 32'h00, {24'h0, d[15:8]}, 4'hF, 32'hFF);
		for (r = 0; r < 4; r = r + 1) begin
			wb(1, 32'h20 + r * 4, 32'h58 + (r & 1) * 4 + r % 3, 4'hF, 0);
			a = {1'b1, r[1:0], 29'h1C};
			d = $urandom;
			w = 1 + $urandom % 15;
			wb(1, a, d, w[3:0], 0);
			check(tries > 0, 1);
			check(p_lwd, d);
			check(jf, {2'b11, ~w[3:0], r[1:0], 2'(r % 3), r[0]});
			wb(0, a, 32'hC0DE0000 ^ {3'h0, a[28:0]}, 4'hF, ALL);
			wb(0, a + 4, 0, 4'hF, ALL);
			check(tries, 0);
		end
		dly <= 8'd20;
		wb(1, 32'h10, 32'h1, 4'hF, 0);
		w = p_jobs;
		for (i = 0; i < 8; i = i + 1) begin
			d = $urandom;
			wb(1, 32'h80000000 + i * 4, d, 4'hF, 0);
			check(tries, 0);
		end
		repeat (400) @(posedge clk_i);
		check(p_jobs - w[7:0], 8);
		check(p_lwd, d);
		dly <= 8'd3;
		wb(1, 32'h10, 32'h2, 4'hF, 0);
		wb(0, 32'h80000000, 32'hC0DE0000, 4'hF, ALL);
		repeat (60) @(posedge clk_i);
		wb(0, 32'h80000004, 32'hC0DE0004, 4'hF, ALL);
		check(tries, 0);
		dly <= 8'd0;
		for (w = 0; w < 8; w = w + 7) begin
			wb(1, 32'h10, 32'h4 + w * 8, 4'hF, 0);
			ao(1, 3'h4, 4'h0, 0);
			ao(0, 3'h4, 4'h0, 0);
			check(ao_rd, 32'h4 + w * 8);
			rl = 0;
			d = $urandom;
			wb(1, 32'h80000008, d, 4'hF, 0);
			check(rl, w + 1);
			check(p_lwd, d);
		end
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, 32'h10, 0, 4'hF, ALL);
		check(req_n, 1);
		report_and_stop;
	end
endmodule
